// ==== dv/qsscr_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsscr_checker
    import qsscr_pkg::*;
(
    input wire logic        CLK_I,     // clock
    input wire logic        SRST_I,    // reset
    input wire logic        PSEL_I,    // apb
    input wire logic        PENABLE_I, // apb
    input wire logic        PWRITE_I,  // apb
    input wire logic [31:0] PADDR_I,   // apb
    input wire logic [31:0] PWDATA_I,  // apb
    input wire logic [3:0]  PSTRB_I,   // apb
    input wire logic [31:0] PRDATA_O,  // apb
    input wire logic        PREADY_O,  // apb
    input wire logic        PSLVERR_O, // apb
    input wire logic        SCK_O,     // serial clock
    input wire logic [3:0]  PCS_O,     // chip selects
    input wire logic        IRQ_O      // request
);
    logic [29:0] idx;
    logic        acc, wr_ok, is_reg, is_ram, c3v_d, c3v_q;
    logic [2:0]  c3_d, c3_q;
    logic [1:0]  ie_d, ie_q;
    assign idx    = PADDR_I[31:2];
    assign acc    = PSEL_I & PENABLE_I;
    assign wr_ok  = acc & PREADY_O & PWRITE_I;
    assign is_reg = idx == CTRL3_STATUS_IDX || idx == CTRL2_IDX || idx == CONFIG_IDX;
    assign is_ram = idx >= RAM_BASE_IDX && idx < RAM_BASE_IDX + 30'(RAM_WORDS);
    // shadow of what software last put in control three and the irq enables
    always_comb begin
        c3_d  = c3_q;
        c3v_d = c3v_q;
        ie_d  = ie_q;
        if (wr_ok && idx == CTRL3_STATUS_IDX && PSTRB_I[1]) begin
            c3_d  = PWDATA_I[LOOPBACK_BIT:HALT_BIT];
            c3v_d = 1'b1;
            ie_d[0] = PWDATA_I[HALT_FAULT_IRQ_ENABLE_BIT];
        end
        if (wr_ok && idx == CTRL2_IDX && PSTRB_I[1]) begin
            ie_d[1] = PWDATA_I[DONE_IE_BIT];
        end
    end
    always_ff @(posedge CLK_I) begin
        c3_q  <= SRST_I ? 3'h0 : c3_d;
        c3v_q <= SRST_I ? 1'b0 : c3v_d;
        ie_q  <= SRST_I ? 2'h0 : ie_d;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    a_reg_nowait: assert property (acc && is_reg |-> PREADY_O)
        else $error("register access stalled");
    a_wait_bound: assert property (acc && !PREADY_O |-> ##[1:2] PREADY_O)
        else $error("ram access stalled past two waits");
    a_unmapped_err: assert property (acc && !is_reg && !is_ram |-> PSLVERR_O)
        else $error("unmapped access without error");
    a_err_phase: assert property (PSLVERR_O |-> acc && !is_reg && !is_ram)
        else $error("error outside unmapped access");
    a_ctrl3_back: assert property (acc && PREADY_O && !PWRITE_I && idx == CTRL3_STATUS_IDX
        && c3v_q |-> PRDATA_O[LOOPBACK_BIT:HALT_BIT] == c3_q)
        else $error("control three readback differs");
    a_irq_gate: assert property (ie_q == 2'h0 && $past(ie_q) == 2'h0 |-> !IRQ_O)
        else $error("request with enables off");
    a_sck_half: assert property ($rose(SCK_O) |=> $stable(SCK_O) [*7])
        else $error("serial clock high phase short");
    a_reset_idle: assert property (@(posedge CLK_I) disable iff (1'b0)
        SRST_I |=> PREADY_O && !IRQ_O && !SCK_O && PCS_O == 4'h0)
        else $error("outputs not idle after reset");
    c_wait: cover property (acc && !PREADY_O);
    c_irq: cover property ($rose(IRQ_O));
    c_sck: cover property ($rose(SCK_O));
endmodule // qsscr_checker
bind qsscr_top qsscr_checker u_chk (.CLK_I, .SRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
    .PWDATA_I, .PSTRB_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .SCK_O, .PCS_O, .IRQ_O);
`default_nettype wire

// ==== dv/qsscr_spi_peer.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsscr_spi_peer (
    input  wire logic       clk_i,   // bench clock
    input  wire logic [3:0] pcs_i,   // chip selects
    input  wire logic       fault_i, // claim the bus
    output logic            miso_o,  // data to unit
    output logic            ss_n_o   // select seen by unit
);
    logic idle_q = 1'b0;
    // released line toggles so stale data never looks valid
    always_ff @(posedge clk_i) idle_q <= ~idle_q;
    assign miso_o = (pcs_i != 4'h0) ? 1'b1 : idle_q;
    assign ss_n_o = ~fault_i;
endmodule // qsscr_spi_peer
`default_nettype wire

// ==== dv/qsscr_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsscr_top_tb
    import qsscr_pkg::*;
;
    localparam logic [31:0] A_ST  = {CTRL3_STATUS_IDX, 2'b00};
    localparam logic [31:0] A_C2  = {CTRL2_IDX, 2'b00};
    localparam logic [31:0] A_CF  = {CONFIG_IDX, 2'b00};
    localparam logic [31:0] A_RAM = {RAM_BASE_IDX, 2'b00};
    localparam logic [31:0] A_BAD = {CONFIG_IDX + 30'h4, 2'b00};
    logic        CLK_I, SRST_I, PSEL_I, PENABLE_I, PWRITE_I, FREEZE_I, MISO_I, SS_N_I;
    logic        PREADY_O, PSLVERR_O, SCK_O, MOSI_O, IRQ_O, err_q, fault;
    logic [31:0] PADDR_I, PWDATA_I, PRDATA_O, rd_q, tx, w, a;
    logic [3:0]  PSTRB_I, PCS_O;
    int          bad_count, checks, n, nw;
    logic [3:0]  pcs_seen;
    logic [7:0]  mosi_sr;
    qsscr_top u_dut (.CLK_I, .SRST_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I,
        .PSTRB_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .MISO_I, .SS_N_I, .FREEZE_I, .SCK_O,
        .MOSI_O, .PCS_O, .IRQ_O);
    qsscr_spi_peer u_peer (.clk_i(CLK_I), .pcs_i(PCS_O), .fault_i(fault), .miso_o(MISO_I),
        .ss_n_o(SS_N_I));
    // serial data and selects as a peripheral sees them on each rising clock
    always @(posedge SCK_O) {pcs_seen, mosi_sr} <= {PCS_O, mosi_sr[6:0], MOSI_O};
    function automatic logic [15:0] rx_of(input logic [15:0] t, input logic l16);
        return l16 ? t : {8'h00, t[7:0]};
    endfunction
    task automatic apb(input logic wr, input logic [31:0] ad, input logic [31:0] d,
                       input logic [3:0] s);
        int k;
        @(posedge CLK_I);
        PSEL_I <= 1'b1;
        PWRITE_I <= wr;
        PADDR_I <= ad;
        PWDATA_I <= d;
        PSTRB_I <= s;
        @(posedge CLK_I);
        PENABLE_I <= 1'b1;
        k = 0;
        do begin
            @(posedge CLK_I);
            k++;
        end while (PREADY_O !== 1'b1 && k < 20);
        if (PREADY_O !== 1'b1) bad_count++;
        nw = k - 1;
        rd_q = PRDATA_O;
        err_q = PSLVERR_O;
        PSEL_I <= 1'b0;
        PENABLE_I <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [31:0] ad, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, ad, 32'h0, 4'h0);
        chk(rd_q & m, e);
    endtask
    task automatic wait_flag(input int b);
        int k;
        k = 0;
        do begin
            apb(1'b0, A_ST, 32'h0, 4'h0);
            k++;
        end while (rd_q[b] !== 1'b1 && k < 300);
        chk({31'h0, rd_q[b]}, 32'h1);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end
    initial begin
        #500000;
        bad_count++;
        tally_and_finish();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {PSEL_I, PENABLE_I, PWRITE_I, FREEZE_I, fault} = 5'h00;
        {PADDR_I, PWDATA_I, PSTRB_I} = 68'h0;
        SRST_I = 1'b1;
        bad_count = 0;
        checks = 0;
        n = $urandom(32'h8BAB);
        repeat (4) @(posedge CLK_I);
        SRST_I <= 1'b0;
        rd_chk(A_ST, 32'h0000_07FF, 32'h0);
        apb(1'b1, A_BAD, $urandom, 4'hF);
        chk({31'h0, err_q}, 32'h1);
        apb(1'b1, A_ST, 32'h0000_06FF, 4'h3);
        rd_chk(A_ST, 32'h0000_07FF, 32'h0000_0600);
        $display("test map done");
        tx = $urandom;
        apb(1'b1, A_RAM, 32'hFFFF_FFFF, 4'hF);
        apb(1'b1, A_RAM + 32'h40, tx, 4'hF);
        apb(1'b1, A_RAM + 32'h80, 32'h0000_0241, 4'hF);          // 16 then 8 bits
        apb(1'b1, A_C2, 32'h0000_0100, 4'hF);
        apb(1'b1, A_CF, 32'h0000_000B, 4'hF);
        wait_flag(DONE_BIT);
        rd_chk(A_ST, 32'h0000_00BF, 32'h0000_0081);
        rd_chk(A_RAM, 32'hFFFF_FFFF, {rx_of(tx[31:16], 1'b0), rx_of(tx[15:0], 1'b1)});
        apb(1'b1, A_ST, 32'h0000_0080, 4'h1);
        apb(1'b1, A_ST, 32'h0, 4'h1);                            // no read in between
        rd_chk(A_ST, 32'h0000_0080, 32'h0000_0080);
        apb(1'b1, A_ST, 32'h0, 4'h1);
        rd_chk(A_ST, 32'h0000_0080, 32'h0);
        $display("test loop done");
        apb(1'b1, A_CF, 32'h0, 4'hF);
        apb(1'b1, A_ST, 32'h0000_0200, 4'h2);
        apb(1'b1, A_CF, 32'h0000_0003, 4'hF);
        fault <= 1'b1;
        repeat (6) @(posedge CLK_I);
        fault <= 1'b0;
        repeat (4) @(posedge CLK_I);
        rd_chk(A_ST, 32'h0000_0040, 32'h0000_0040);
        chk({31'h0, IRQ_O}, 32'h1);
        apb(1'b1, A_ST, 32'h0, 4'h1);
        repeat (3) @(posedge CLK_I);
        chk({31'h0, IRQ_O}, 32'h0);
        $display("test fault done");
        apb(1'b1, A_CF, 32'h0, 4'hF);
        apb(1'b1, A_RAM + 32'h80, 32'h0000_0001, 4'hF);
        apb(1'b1, A_C2, 32'h0000_4000, 4'hF);
        apb(1'b1, A_CF, 32'h0000_000B, 4'hF);
        // access phase meets the store and load cycles of the first pass
        repeat (127) @(posedge CLK_I);
        apb(1'b1, A_RAM + 32'h4, 32'h0000_00A5, 4'h1);
        chk({31'h0, (nw >= 1 && nw <= 2)}, 32'h1);
        rd_chk(A_RAM + 32'h4, 32'h0000_00FF, 32'h0000_00A5);
        wait_flag(DONE_BIT);
        apb(1'b1, A_ST, 32'h0, 4'h1);
        // reads race the running engine for the ram
        for (n = 0; n < 8; n++) rd_chk(A_RAM + 32'h40, 32'hFFFF_FFFF, tx);
        rd_chk(A_RAM, 32'h0000_FFFF, {16'h0, rx_of(16'hFFFF, 1'b0)});
        wait_flag(DONE_BIT);
        apb(1'b1, A_ST, 32'h0000_0300, 4'h2);
        wait_flag(HALT_ACK_FLAG_BIT);
        w = 32'h0;
        repeat (40) begin
            @(posedge CLK_I);
            w = w | {31'h0, SCK_O};
        end
        chk(w, 32'h0);
        chk({20'h0, pcs_seen, mosi_sr}, {20'h0, 4'h1, tx[7:0]});
        chk({31'h0, IRQ_O}, 32'h1);
        apb(1'b1, A_ST, 32'h0000_0200, 4'h2);
        apb(1'b1, A_ST, 32'h0, 4'h1);
        wait_flag(DONE_BIT);
        $display("test halt done");
        // let the queue run out before disabling, so no transfer is cut
        apb(1'b1, A_ST, 32'h0, 4'h1);
        apb(1'b1, A_C2, 32'h0, 4'hF);
        wait_flag(DONE_BIT);
        apb(1'b1, A_CF, 32'h0000_0004, 4'hF);
        rd_chk(A_ST, 32'h0000_0020, 32'h0);
        FREEZE_I <= 1'b1;
        repeat (5) @(posedge CLK_I);
        rd_chk(A_ST, 32'h0000_0020, 32'h0000_0020);
        FREEZE_I <= 1'b0;
        for (n = 0; n < 8; n++) begin
            a = A_RAM + (32'($urandom_range(39)) << 2);
            tx = $urandom;
            w = $urandom;
            apb(1'b1, a, tx, 4'hF);
            apb(1'b1, a, w, 4'h2);
            rd_chk(a, 32'hFFFF_FFFF, {tx[31:16], w[15:8], tx[7:0]});
        end
        $display("test ram done");
        tally_and_finish();
    end
endmodule // qsscr_top_tb
`default_nettype wire

// ==== src/qsscr_pkg.sv ====
package qsscr_pkg;

    // ------------------------------------------------------------
    // register indexes (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [29:0] CTRL3_STATUS_IDX  = 30'h0030501E;
    localparam logic [29:0] CTRL2_IDX         = 30'h0030501C;
    localparam logic [29:0] CONFIG_IDX        = 30'h00305020;
    localparam logic [29:0] RAM_BASE_IDX      = 30'h00305040;
    localparam int          RAM_WORDS         = 40;
    localparam int          RAM_HALFWORDS     = 80;
    localparam logic [6:0]  TX_HW_BASE        = 7'h20;
    localparam logic [6:0]  CMD_HW_BASE       = 7'h40;

    // ------------------------------------------------------------
    // third control byte / status byte word bits
    // ------------------------------------------------------------
    localparam int LOOPBACK_BIT   = 10;
    localparam int HALT_FAULT_IRQ_ENABLE_BIT       = 9;
    localparam int HALT_BIT       = 8;
    localparam int DONE_BIT       = 7;
    localparam int MODE_FAULT_FLAG_BIT       = 6;
    localparam int HALT_ACK_FLAG_BIT      = 5;
    localparam int CPTR_MSB       = 4;
    localparam logic [4:0] CPTR_RESET = 5'h00;

    // ------------------------------------------------------------
    // second control word bits
    // ------------------------------------------------------------
    localparam int DONE_IE_BIT    = 15;
    localparam int WRAP_EN_BIT    = 14;
    localparam int WRAP_TO_BIT    = 13;
    localparam int ENDQ_MSB       = 12;
    localparam int ENDQ_LSB       = 8;
    localparam int NEWQ_MSB       = 4;

    // ------------------------------------------------------------
    // config register bits
    // ------------------------------------------------------------
    localparam int UNIT_EN_BIT    = 0;
    localparam int MASTER_BIT     = 1;
    localparam int FRZ_EN_BIT     = 2;
    localparam int START_BIT      = 3;

    // command byte: bit 6 selects 16-bit transfers, bits 3:0 chip selects
    localparam int CMD_LEN16_BIT  = 6;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ        = 100;
    localparam int          SCK_HALF_NS    = 80;
    localparam logic [7:0]  SCK_HALF_CYC   = 8'((SCK_HALF_NS * CLK_MHZ) / 1000);
    localparam logic [4:0]  LEN8           = 5'h08;
    localparam logic [4:0]  LEN16          = 5'h10;

    typedef struct packed {
        logic loopback;
        logic halt_fault_irq_enable;
        logic halt;
    } qsscr_ctrl3_t;

    typedef struct packed {
        logic       done;
        logic       mode_fault_flag;
        logic       halt_ack_flag;
        logic [4:0] cptr;
    } qsscr_status_t;

    typedef enum {
        QS_IDLE,
        QS_LOAD,
        QS_SHIFT,
        QS_STORE,
        QS_HALTED
    } qsscr_state_t;

endpackage

// ==== src/qsscr_top.sv ====
// Operation
// - loopback bit feeds serializer output back to its input for test
// - interrupt enable bit gates halt-ack and mode-fault flags onto request
// - halt request stops the queue only between commands; resumable state
// - CPU reads and writes the third control byte; engine only reads it
// - flags set by hardware only; cleared by read-with-set then write zero
// - completed-command pointer ignores CPU writes; engine updates it
// - queue-done set after ending command; again every wrapped pass
// - mode fault set when enabled master sees slave-select pulled low
// - halt-ack set when the engine actually comes to rest on halt
// - halt-ack also set on debug freeze while freeze enable is one
// - completed pointer holds last executed command, updated per command
// - 160-byte dual-ported RAM shared by engine and CPU
// - CPU RAM access stretched by at most two wait states
// - byte, half-word, word access; word access locks out the engine
// - RAM split into receive, transmit and command segments
// - received words stored right-justified
// - unfilled receive bits written as zero at entry completion
// - after each command compare its address with ending pointer
// - wrap to address zero or first-command pointer per wrap select
`timescale 1ns/1ps
`default_nettype none

module qsscr_top
    import qsscr_pkg::*;
(
    input  wire logic        CLK_I,      // system clock
    input  wire logic        SRST_I,     // sync reset, active high
    input  wire logic        PSEL_I,     // apb select
    input  wire logic        PENABLE_I,  // apb access phase
    input  wire logic        PWRITE_I,   // apb direction
    input  wire logic [31:0] PADDR_I,    // apb byte address
    input  wire logic [31:0] PWDATA_I,   // apb write data
    input  wire logic [3:0]  PSTRB_I,    // apb byte strobes
    output logic      [31:0] PRDATA_O,   // apb read data
    output logic             PREADY_O,   // apb ready
    output logic             PSLVERR_O,  // apb error on unmapped address
    input  wire logic        MISO_I,     // serial data in
    input  wire logic        SS_N_I,     // slave select in, active low
    input  wire logic        FREEZE_I,   // debug freeze
    output logic             SCK_O,      // serial clock
    output logic             MOSI_O,     // serial data out
    output logic      [3:0]  PCS_O,      // peripheral chip selects
    output logic             IRQ_O       // interrupt request
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]    ram_q [RAM_HALFWORDS];
    qsscr_ctrl3_t   ctrl3_q,  ctrl3_d;
    qsscr_status_t  stat_q,   stat_d;
    logic [2:0]     seen_q,   seen_d;
    logic [15:0]    ctrl2_q,  ctrl2_d;
    logic [2:0]     cfg_q,    cfg_d;
    qsscr_state_t   st_q,     st_d;
    logic [4:0]     qp_q,     qp_d;
    logic [15:0]    tx_q,     tx_d;
    logic [15:0]    rx_q,     rx_d;
    logic [4:0]     cnt_q,    cnt_d;
    logic           len16_q,  len16_d;
    logic [7:0]     div_q,    div_d;
    logic           sck_q,    sck_d;
    logic [3:0]     pcs_q,    pcs_d;
    logic [31:0]    rdata_q,  rdata_d;
    logic           irq_q,    irq_d;
    logic [1:0]     miso_s,   ss_s,     frz_s;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        acc, hit_cs, hit_c2, hit_cfg, hit_ram, mapped;
    logic        cpu_lock, eng_req, ram_wait;
    logic [29:0] widx;
    logic [29:0] woff;
    logic [6:0]  hw0;

    assign widx     = PADDR_I[31:2];
    assign woff     = widx - RAM_BASE_IDX;
    assign hw0      = {woff[5:0], 1'b0};
    assign acc      = PSEL_I & PENABLE_I;
    assign hit_cs   = (widx == CTRL3_STATUS_IDX);
    assign hit_c2   = (widx == CTRL2_IDX);
    assign hit_cfg  = (widx == CONFIG_IDX);
    assign hit_ram  = (widx >= RAM_BASE_IDX) && (woff < 30'(RAM_WORDS));
    assign mapped   = hit_cs | hit_c2 | hit_cfg | hit_ram;
    // word access is coherent: the engine waits for it
    assign cpu_lock = acc & hit_ram & (PSTRB_I == 4'hF | ~PWRITE_I);
    assign eng_req  = (st_q == QS_LOAD || st_q == QS_STORE) && !cpu_lock;
    // engine store and load cycles are back to back, so two waits at most
    assign ram_wait = hit_ram & eng_req & ~cpu_lock;

    assign PREADY_O  = ~ram_wait;
    assign PSLVERR_O = acc & ~mapped;
    assign PRDATA_O  = rdata_q;
    assign SCK_O     = sck_q;
    assign MOSI_O    = tx_q[15];
    assign PCS_O     = pcs_q;
    assign IRQ_O     = irq_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            miso_s <= 2'h0;
            ss_s   <= 2'h3;
            frz_s  <= 2'h0;
        end else begin
            miso_s <= {miso_s[0], MISO_I};
            ss_s   <= {ss_s[0], SS_N_I};
            frz_s  <= {frz_s[0], FREEZE_I};
        end
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic        wr_done, rd_done, ser_in, frozen, at_end, tick;
    logic [15:0] cmd_hw;
    logic [7:0]  cmd_b;
    logic [15:0] rx_fill;
    logic [4:0]  endq, newq;

    always_comb begin
        wr_done = acc & PWRITE_I & PREADY_O & mapped;
        rd_done = acc & ~PWRITE_I & PREADY_O;
        frozen  = frz_s[1] & cfg_q[FRZ_EN_BIT];
        endq    = ctrl2_q[ENDQ_MSB:ENDQ_LSB];
        newq    = ctrl2_q[NEWQ_MSB:0];
        at_end  = (qp_q == endq);
        cmd_hw  = ram_q[CMD_HW_BASE + 7'(qp_q[4:1])];
        cmd_b   = qp_q[0] ? cmd_hw[15:8] : cmd_hw[7:0];
        ser_in  = ctrl3_q.loopback ? tx_q[15] : miso_s[1];
        rx_fill = len16_q ? rx_q : {8'h00, rx_q[7:0]};
        tick    = (div_q == 8'h01);

        ctrl3_d = ctrl3_q;
        stat_d  = stat_q;
        seen_d  = seen_q;
        ctrl2_d = ctrl2_q;
        cfg_d   = cfg_q;
        st_d    = st_q;
        qp_d    = qp_q;
        tx_d    = tx_q;
        rx_d    = rx_q;
        cnt_d   = cnt_q;
        len16_d = len16_q;
        div_d   = div_q;
        sck_d   = sck_q;
        pcs_d   = pcs_q;
        rdata_d = rdata_q;

        // read data captured one cycle ahead of the answer
        if (PSEL_I) begin
            rdata_d = 32'h0000_0000;
            if (hit_cs) begin
                rdata_d[LOOPBACK_BIT] = ctrl3_q.loopback;
                rdata_d[HALT_FAULT_IRQ_ENABLE_BIT]     = ctrl3_q.halt_fault_irq_enable;
                rdata_d[HALT_BIT]     = ctrl3_q.halt;
                rdata_d[DONE_BIT]     = stat_q.done;
                rdata_d[MODE_FAULT_FLAG_BIT]     = stat_q.mode_fault_flag;
                rdata_d[HALT_ACK_FLAG_BIT]    = stat_q.halt_ack_flag;
                rdata_d[CPTR_MSB:0]   = stat_q.cptr;
            end else if (hit_c2) begin
                rdata_d[15:0] = ctrl2_q;
            end else if (hit_cfg) begin
                rdata_d[2:0] = cfg_q;
            end else if (hit_ram) begin
                rdata_d = {ram_q[hw0 + 7'h01], ram_q[hw0]};
            end
        end

        // ---------------- cpu register writes ----------------
        if (wr_done && hit_cs) begin
            if (PSTRB_I[1]) begin
                ctrl3_d.loopback = PWDATA_I[LOOPBACK_BIT];
                ctrl3_d.halt_fault_irq_enable     = PWDATA_I[HALT_FAULT_IRQ_ENABLE_BIT];
                ctrl3_d.halt     = PWDATA_I[HALT_BIT];
            end
            if (PSTRB_I[0]) begin
                // zero clears only a flag seen set by an earlier read
                if (!PWDATA_I[DONE_BIT] && seen_q[2]) stat_d.done  = 1'b0;
                if (!PWDATA_I[MODE_FAULT_FLAG_BIT] && seen_q[1]) stat_d.mode_fault_flag  = 1'b0;
                if (!PWDATA_I[HALT_ACK_FLAG_BIT] && seen_q[0]) stat_d.halt_ack_flag = 1'b0;
                seen_d = 3'h0;
            end
            // pointer field never takes cpu data
        end
        // remember what the answer showed, not a flag set during the access
        if (rd_done && hit_cs) begin
            seen_d = {rdata_q[DONE_BIT], rdata_q[MODE_FAULT_FLAG_BIT], rdata_q[HALT_ACK_FLAG_BIT]};
        end
        if (wr_done && hit_c2) begin
            if (PSTRB_I[1]) ctrl2_d[15:8] = PWDATA_I[15:8];
            if (PSTRB_I[0]) ctrl2_d[7:0]  = PWDATA_I[7:0];
        end
        if (wr_done && hit_cfg && PSTRB_I[0]) begin
            cfg_d = PWDATA_I[2:0];
        end

        // ---------------- flag sources (set beats clear) ----------------
        if (cfg_q[UNIT_EN_BIT] && cfg_q[MASTER_BIT] && !ss_s[1]) begin
            stat_d.mode_fault_flag = 1'b1;
        end
        if (frozen) begin
            stat_d.halt_ack_flag = 1'b1;
        end

        // ---------------- serial engine ----------------
        case (st_q)
            QS_IDLE: begin
                if (wr_done && hit_cfg && PSTRB_I[0] && PWDATA_I[START_BIT]
                    && cfg_d[UNIT_EN_BIT]) begin
                    qp_d = newq;
                    st_d = QS_LOAD;
                end
            end
            QS_LOAD: begin
                if (!cpu_lock) begin
                    len16_d = cmd_b[CMD_LEN16_BIT];
                    pcs_d   = cmd_b[3:0];
                    tx_d    = cmd_b[CMD_LEN16_BIT] ?
                              ram_q[TX_HW_BASE + 7'(qp_q)] :
                              {ram_q[TX_HW_BASE + 7'(qp_q)][7:0], 8'h00};
                    rx_d    = 16'h0000;
                    cnt_d   = cmd_b[CMD_LEN16_BIT] ? LEN16 : LEN8;
                    div_d   = SCK_HALF_CYC;
                    sck_d   = 1'b0;
                    st_d    = QS_SHIFT;
                end
            end
            QS_SHIFT: begin
                div_d = tick ? SCK_HALF_CYC : div_q - 8'h01;
                if (tick) begin
                    sck_d = ~sck_q;
                    if (!sck_q) begin
                        rx_d = {rx_q[14:0], ser_in};
                    end else begin
                        tx_d  = {tx_q[14:0], 1'b0};
                        cnt_d = cnt_q - 5'h01;
                        if (cnt_q == 5'h01) st_d = QS_STORE;
                    end
                end
            end
            QS_STORE: begin
                if (!cpu_lock) begin
                    stat_d.cptr = qp_q;
                    pcs_d = 4'h0;
                    if (at_end) stat_d.done = 1'b1;
                    if (at_end && !ctrl2_q[WRAP_EN_BIT]) begin
                        st_d  = QS_IDLE;
                    end else begin
                        if (at_end) begin
                            qp_d = ctrl2_q[WRAP_TO_BIT] ? newq : 5'h00;
                        end else begin
                            qp_d = qp_q + 5'h01;
                        end
                        // halt only lands between commands
                        if (ctrl3_q.halt || frozen) begin
                            st_d = QS_HALTED;
                            stat_d.halt_ack_flag = 1'b1;
                        end else begin
                            st_d = QS_LOAD;
                        end
                    end
                end
            end
            QS_HALTED: begin
                if (!ctrl3_q.halt && !frozen) st_d = QS_LOAD;
            end
            default: st_d = QS_IDLE;
        endcase
        if (!cfg_d[UNIT_EN_BIT]) begin
            st_d  = QS_IDLE;
            pcs_d = 4'h0;
            sck_d = 1'b0;
        end

        irq_d = (ctrl3_q.halt_fault_irq_enable & (stat_q.halt_ack_flag | stat_q.mode_fault_flag))
              | (ctrl2_q[DONE_IE_BIT] & stat_q.done);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ctrl3_q <= '0;
            stat_q  <= '{done: 1'b0, mode_fault_flag: 1'b0, halt_ack_flag: 1'b0, cptr: CPTR_RESET};
            seen_q  <= 3'h0;
            ctrl2_q <= 16'h0000;
            cfg_q   <= 3'h0;
            st_q    <= QS_IDLE;
            qp_q    <= 5'h00;
            tx_q    <= 16'h0000;
            rx_q    <= 16'h0000;
            cnt_q   <= 5'h00;
            len16_q <= 1'b0;
            div_q   <= 8'h00;
            sck_q   <= 1'b0;
            pcs_q   <= 4'h0;
            rdata_q <= 32'h0000_0000;
            irq_q   <= 1'b0;
        end else begin
            ctrl3_q <= ctrl3_d;
            stat_q  <= stat_d;
            seen_q  <= seen_d;
            ctrl2_q <= ctrl2_d;
            cfg_q   <= cfg_d;
            st_q    <= st_d;
            qp_q    <= qp_d;
            tx_q    <= tx_d;
            rx_q    <= rx_d;
            cnt_q   <= cnt_d;
            len16_q <= len16_d;
            div_q   <= div_d;
            sck_q   <= sck_d;
            pcs_q   <= pcs_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // shared queue RAM: receive 0x00-0x1F, transmit 0x20-0x3F,
    // command bytes 0x40-0x4F (halfword index)
    // ------------------------------------------------------------
    // contents are not reset; software loads them before a queue runs
    for (genvar g = 0; g < RAM_HALFWORDS; g++) begin : g_ram
        logic [15:0] nxt;
        logic        cpu_lo, cpu_hi;
        always_comb begin
            nxt    = ram_q[g];
            cpu_lo = wr_done && hit_ram && (7'(g) == hw0);
            cpu_hi = wr_done && hit_ram && (7'(g) == hw0 + 7'h01);
            if (cpu_lo && PSTRB_I[0]) nxt[7:0]  = PWDATA_I[7:0];
            if (cpu_lo && PSTRB_I[1]) nxt[15:8] = PWDATA_I[15:8];
            if (cpu_hi && PSTRB_I[2]) nxt[7:0]  = PWDATA_I[23:16];
            if (cpu_hi && PSTRB_I[3]) nxt[15:8] = PWDATA_I[31:24];
            if (st_q == QS_STORE && !cpu_lock && 7'(g) == 7'(qp_q)) begin
                nxt = rx_fill;
            end
        end
        always_ff @(posedge CLK_I) begin
            ram_q[g] <= nxt;
        end
    end

endmodule // qsscr_top

`default_nettype wire
